/* core/fdr_smoothing.sv */
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Ramp control register clears at reset
// - Rate field caps remote-one driven duty change
// - Duty ramps by coded per-slot increment
// - Normal slot timing gives listed ramp times
// - Slowdown bit gives the longer ramp times
// - Smoothing only while enable bit set
// - Group bit lets fan three drive three
// - Fan one below start: off or minimum
// - Fan two below start: off or minimum
// - Fan three below start: off or minimum
// - Lock makes ramp control read-only
// - Per-channel bit slows ramp four times
// - Remote-one governed means behaviour code zero
`include "fdr_cfg.svh"

module fdr_smoothing #(
    parameter int unsigned SLOT_NORM_CYC = 32'(`FDR_SLOT_NORM_CYC),
    parameter int unsigned SLOT_SLOW_CYC = 32'(`FDR_SLOT_SLOW_CYC)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire fdr_pkg::fdr_fan_demand_s demand_one,
    input wire fdr_pkg::fdr_fan_demand_s demand_two,
    input wire fdr_pkg::fdr_fan_demand_s demand_three,
    output logic [7:0] fan_drive_one,
    output logic [7:0] fan_drive_two,
    output logic [7:0] fan_drive_three,
    output logic fan_three_group
);
    import fdr_pkg::*;

    // Increment per slot for a rate code
    function automatic logic [7:0] rate_step(input logic [2:0] code);
        case (code)
            3'h0: rate_step = 8'h01;
            3'h1: rate_step = 8'h02;
            3'h2: rate_step = 8'h03;
            3'h3: rate_step = 8'h04;
            3'h4: rate_step = 8'h08;
            3'h5: rate_step = 8'h0C;
            3'h6: rate_step = 8'h18;
            default: rate_step = 8'h30;
        endcase
    endfunction : rate_step

    // Move toward goal by at most inc, never past it
    function automatic logic [7:0] ramp_toward(input logic [7:0] cur, input logic [7:0] goal,
                                               input logic [7:0] inc);
        logic [7:0] gap;
        gap = (cur < goal) ? (goal - cur) : (cur - goal);
        if (gap <= inc)
            ramp_toward = goal;
        else if (cur < goal)
            ramp_toward = cur + inc;
        else
            ramp_toward = cur - inc;
    endfunction : ramp_toward

    fdr_ramp_ctrl_s ramp_ctrl; // Ramp control register
    logic [7:0] cfg6; // Slowdown and per-channel quarter-rate bits
    logic locked; // Sticky configuration lock
    logic [8:0] behaviour; // Three 3-bit behaviour codes, fan one lowest
    fdr_bus_state_e bus_state; // Bus phase
    logic [7:0] bus_index; // Word index of the access
    logic [31:0] slot_cnt; // Ramp slot timer
    logic [31:0] slot_limit; // Cycles per slot for current settings
    logic slot_tick; // One-cycle pulse each ramp slot
    logic [7:0] step_inc; // Selected increment
    logic [7:0] goal [3]; // Target per fan after behaviour and floor
    logic [2:0] smoothing; // Fan is remote-one governed and smoothing is on
    logic [7:0] drive [3]; // Present duty per fan
    fdr_fan_demand_s demand [3];

    assign demand[0] = demand_one;
    assign demand[1] = demand_two;
    assign demand[2] = demand_three;
    assign bus_index = avs_address[9:2];
    assign step_inc = rate_step(ramp_ctrl.rate);

    // Slot length: slowdown picks the longer base, the quarter bit stretches it fourfold
    always_comb
    begin
        // Slowdown alone picks the base; the smoothing enable plays no part in slot length
        slot_limit = cfg6[`FDR_POS_SLOWDOWN] ? SLOT_SLOW_CYC : SLOT_NORM_CYC;
        // A limit of one cycle ticks every cycle, while zero wraps to a near-endless slot; the defaults sit far above that
        if (cfg6[`FDR_POS_QUAD_R1])
            slot_limit = {slot_limit[29:0], 2'b00};
    end

    assign slot_tick = (slot_cnt >= slot_limit - 32'h1);

    // Free-running slot timer; restarts if the limit shrinks below the count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            slot_cnt <= 32'h0;
        else if (slot_tick)
            slot_cnt <= 32'h0;
        else
            slot_cnt <= slot_cnt + 32'h1;
    end

    // Goal per fan from behaviour code and the below-start floor choice
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            case (fdr_behaviour_e'(behaviour[3*i +: 3]))
                FDR_BHV_FULL: goal[i] = 8'hFF;
                FDR_BHV_OFF: goal[i] = 8'h00;
                FDR_BHV_MANUAL: goal[i] = demand[i].target;
                default:
                begin
                    // Automatic modes: below start less hysteresis, off or floor
                    if (demand[i].below_start)
                        goal[i] = ramp_ctrl[`FDR_POS_FLOOR1 + i] ? demand[i].min_duty : 8'h00;
                    else
                        goal[i] = demand[i].target;
                end
            endcase
            // Only remote-one governed fans ramp, and only with smoothing on
            smoothing[i] = ramp_ctrl.smooth_en && (behaviour[3*i +: 3] == FDR_BHV_REMOTE1);
        end
    end

    // Duty update: smoothed fans step once per slot, others follow the goal at once
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            drive[0] <= 8'h00;
            drive[1] <= 8'h00;
            drive[2] <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (!smoothing[i])
                    drive[i] <= goal[i];
                else if (slot_tick)
                    drive[i] <= ramp_toward(drive[i], goal[i], step_inc);
            end
        end
    end

    assign fan_drive_one = drive[0];
    assign fan_drive_two = drive[1];
    assign fan_drive_three = drive[2];

    // Group mode flag toward the tach routing, registered
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            fan_three_group <= 1'b0;
        else
            fan_three_group <= ramp_ctrl.group;
    end

    // Bus handshake: waitrequest drops for one cycle, then the access completes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bus_state <= FDR_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else
        begin
            case (bus_state)
                FDR_BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_state <= FDR_BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        // Unmapped indices read as zero
                        case (bus_index)
                            `FDR_IDX_RAMP_CTRL: avs_readdata <= {24'h0, ramp_ctrl};
                            `FDR_IDX_CFG6: avs_readdata <= {24'h0, cfg6};
                            `FDR_IDX_LOCK: avs_readdata <= {31'h0, locked};
                            `FDR_IDX_BEHAVIOUR: avs_readdata <= {23'h0, behaviour};
                            `FDR_IDX_DUTY_STATUS: avs_readdata <= {8'h0, drive[2], drive[1], drive[0]};
                            default: avs_readdata <= 32'h0;
                        endcase
                    end
                end
                FDR_BUS_ACK:
                begin
                    bus_state <= FDR_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_state <= FDR_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Register writes take effect at the edge where waitrequest is seen low
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ramp_ctrl <= `FDR_RST_RAMP_CTRL;
            cfg6 <= `FDR_RST_CFG6;
            locked <= 1'b0;
            behaviour <= `FDR_RST_BEHAVIOUR;
        end
        else if (avs_write && !avs_waitrequest)
        begin
            case (bus_index)
                `FDR_IDX_RAMP_CTRL:
                begin
                    // Once locked, writes are dropped silently
                    if (!locked)
                        ramp_ctrl <= avs_writedata[7:0];
                end
                `FDR_IDX_CFG6: cfg6 <= avs_writedata[7:0];
                // Lock can only be set; only reset clears it
                `FDR_IDX_LOCK: locked <= locked | avs_writedata[`FDR_POS_LOCK];
                `FDR_IDX_BEHAVIOUR: behaviour <= avs_writedata[8:0];
                default: ;
            endcase
        end
    end

    // Checks kept beside the logic

    a_reset_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ramp_ctrl == 8'h00)
        else $error("ramp control not clear after reset");

    a_slot_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cfg6[7] && !cfg6[0] |-> slot_limit == SLOT_NORM_CYC)
        else $error("normal slot length wrong");

    a_slow_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg6[7] && !cfg6[0] |-> slot_limit == SLOT_SLOW_CYC)
        else $error("slowdown slot length wrong");

    a_quad_slowdown: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg6[0] |-> slot_limit == 4 * (cfg6[7] ? SLOT_SLOW_CYC : SLOT_NORM_CYC))
        else $error("quarter-rate slot length wrong");

    a_step_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        smoothing[0] && $stable(smoothing[0]) |->
        ((drive[0] >= $past(drive[0]) ? drive[0] - $past(drive[0]) : $past(drive[0]) - drive[0])
         <= $past(step_inc)))
        else $error("fan one stepped more than increment");

    a_hold_between: assert property (@(posedge core_clk) disable iff (!rst_n)
        smoothing[1] && !slot_tick ##1 smoothing[1] |-> $stable(drive[1]))
        else $error("smoothed duty moved between slots");

    a_no_overshoot: assert property (@(posedge core_clk) disable iff (!rst_n)
        smoothing[0] && slot_tick && drive[0] < goal[0] |=> drive[0] <= $past(goal[0]))
        else $error("ramp overshot its target");

    a_direct_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        !smoothing[2] |=> drive[2] == $past(goal[2]))
        else $error("unsmoothed fan did not follow goal");

    a_lock_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        locked && avs_write && !avs_waitrequest |=> $stable(ramp_ctrl))
        else $error("locked register changed");

    a_floor_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        behaviour[2:0] == 3'h0 && demand_one.below_start |->
        goal[0] == (ramp_ctrl.floor1 ? demand_one.min_duty : 8'h00))
        else $error("fan one floor wrong");

    a_floor_two: assert property (@(posedge core_clk) disable iff (!rst_n)
        behaviour[5:3] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6} && demand_two.below_start |->
        goal[1] == (ramp_ctrl.floor2 ? demand_two.min_duty : 8'h00))
        else $error("fan two floor wrong");

    a_floor_three: assert property (@(posedge core_clk) disable iff (!rst_n)
        behaviour[8:6] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6} && demand_three.below_start |->
        goal[2] == (ramp_ctrl.floor3 ? demand_three.min_duty : 8'h00))
        else $error("fan three floor wrong");

    a_group_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 1'b1 |-> fan_three_group == $past(ramp_ctrl.group))
        else $error("group flag does not follow register");

    a_remote_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        behaviour[2:0] != 3'h0 |-> !smoothing[0])
        else $error("non remote-one fan smoothed");

endmodule : fdr_smoothing

/* common/fdr_cfg.svh */
`ifndef FDR_CFG_SVH
`define FDR_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define FDR_IDX_RAMP_CTRL 8'h62
`define FDR_IDX_CFG6 8'h10
`define FDR_IDX_LOCK 8'h40
`define FDR_IDX_BEHAVIOUR 8'h70
`define FDR_IDX_DUTY_STATUS 8'h71

// Reset values
`define FDR_RST_RAMP_CTRL 8'h00
`define FDR_RST_CFG6 8'h00
// Every fan starts on the full-speed code, three bits per fan
`define FDR_RST_BEHAVIOUR 9'h0DB

// Field positions in the ramp control register
`define FDR_POS_SMOOTH_EN 3
`define FDR_POS_GROUP 4
`define FDR_POS_FLOOR1 5
`define FDR_POS_FLOOR2 6
`define FDR_POS_FLOOR3 7
// Field positions in configuration register 6
`define FDR_POS_SLOWDOWN 7
`define FDR_POS_QUAD_R1 0
// Lock bit position in the lock register
`define FDR_POS_LOCK 0

// Timing: full 0 to 100 percent ramp at increment 1, in ms
`define FDR_RAMP_NORM_MS 37500
`define FDR_RAMP_SLOW_MS 52200
`define FDR_CLK_KHZ 125000
`define FDR_DUTY_FULL 255
// Cycles per ramp slot, rounded down
`define FDR_SLOT_NORM_CYC ((64'd`FDR_RAMP_NORM_MS * 64'd`FDR_CLK_KHZ) / 64'd`FDR_DUTY_FULL)
`define FDR_SLOT_SLOW_CYC ((64'd`FDR_RAMP_SLOW_MS * 64'd`FDR_CLK_KHZ) / 64'd`FDR_DUTY_FULL)

`endif

/* common/fdr_pkg.sv */
package fdr_pkg;

    // Ramp control register layout
    typedef struct packed {
        logic floor3;
        logic floor2;
        logic floor1;
        logic group;
        logic smooth_en;
        logic [2:0] rate;
    } fdr_ramp_ctrl_s;

    // Demand for one fan from the temperature loop
    typedef struct packed {
        logic [7:0] target;
        logic [7:0] min_duty;
        logic below_start;
    } fdr_fan_demand_s;

    // Per-fan behaviour codes
    typedef enum logic [2:0] {
        FDR_BHV_REMOTE1 = 3'h0,
        FDR_BHV_LOCAL = 3'h1,
        FDR_BHV_REMOTE2 = 3'h2,
        FDR_BHV_FULL = 3'h3,
        FDR_BHV_OFF = 3'h4,
        FDR_BHV_LOC_R2 = 3'h5,
        FDR_BHV_ALL = 3'h6,
        FDR_BHV_MANUAL = 3'h7
    } fdr_behaviour_e;

    // Bus access phases
    typedef enum logic [1:0] {
        FDR_BUS_IDLE = 2'b01,
        FDR_BUS_ACK = 2'b10
    } fdr_bus_state_e;

endpackage : fdr_pkg

/* sim/fdr_fan_model.sv */
`timescale 1ns/1ps
// Fans hung on the third drive; grouped fans report the duty they share
module fdr_fan_model (
    input wire logic core_clk,
    input wire logic [7:0] fan_drive_three,
    input wire logic fan_three_group,
    output logic [7:0] speed_sense_two,
    output logic [7:0] speed_sense_three,
    output logic [7:0] speed_sense_four
);
    // Speed lags drive by a cycle; an ungrouped tach sees a stopped fan
    always_ff @(posedge core_clk)
    begin
        speed_sense_two <= fan_three_group ? fan_drive_three : 8'h00;
        speed_sense_three <= fan_three_group ? fan_drive_three : 8'h00;
        speed_sense_four <= fan_three_group ? fan_drive_three : 8'h00;
    end
endmodule : fdr_fan_model

/* sim/fan_duty_ramp_smoothing_tb.sv */
`timescale 1ns/1ps
module fan_duty_ramp_smoothing_tb;
    import fdr_pkg::*;
    localparam int NORM = 4; // Short slots keep full sweeps brief
    localparam int SLOW = 6;
    localparam int LIMIT = 40000; // Ceiling well above all sweeps
    localparam logic [9:0] CTRL = 10'h188;
    localparam logic [9:0] CFG6 = 10'h040;
    localparam logic [9:0] LOCK = 10'h100;
    localparam logic [9:0] BHV = 10'h1C0;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    fdr_fan_demand_s dem [3]; // Temperature loop demands
    logic [7:0] drv [3]; // Present duties
    logic [7:0] sense [3]; // Tach readings from the fan model
    logic fan_three_group;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    fdr_smoothing #(.SLOT_NORM_CYC(NORM), .SLOT_SLOW_CYC(SLOW)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .demand_one(dem[0]), .demand_two(dem[1]),
        .demand_three(dem[2]), .fan_drive_one(drv[0]), .fan_drive_two(drv[1]),
        .fan_drive_three(drv[2]), .fan_three_group(fan_three_group));
    fdr_fan_model fans (
        .core_clk(core_clk), .fan_drive_three(drv[2]), .fan_three_group(fan_three_group),
        .speed_sense_two(sense[0]), .speed_sense_three(sense[1]), .speed_sense_four(sense[2]));

    // Clock at 125 MHz
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    // Cut a hang short
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        if (seen !== exp)
            num_errors++;
    endtask : check

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd_chk

    task automatic dem_set(input int i, input logic [7:0] t, input logic [7:0] m, input logic b);
        @(posedge core_clk);
        dem[i] <= '{t, m, b};
    endtask : dem_set

    // Reset values, read-back, unmapped place
    task automatic t_reset();
        rd_chk(CTRL, 32'h0);
        check(fan_three_group, 1'b0);
        rd_chk(BHV, 32'h0DB);
        rd_chk(10'h3FC, 32'h0);
        wr(CTRL, 32'hA5);
        rd_chk(CTRL, 32'hA5);
        wr(BHV, 32'h0); // Every fan follows remote one
    endtask : t_reset

    // Smoothing off, or fan on another channel: duty jumps at once
    task automatic t_direct();
        wr(CTRL, 32'h07);
        dem_set(0, 8'hC8, 8'h00, 1'b0);
        repeat (2) @(posedge core_clk);
        check(drv[0], 8'hC8);
        wr(BHV, 32'h08); // Fan two on the local channel
        wr(CTRL, 32'h08); // Smoothing on at the slowest code
        dem_set(1, 8'h9C, 8'h00, 1'b0);
        repeat (2) @(posedge core_clk);
        check(drv[1], 8'h9C);
        wr(BHV, 32'h0);
    endtask : t_direct

    // Below start: off with floor bit clear, minimum duty with it set
    task automatic t_floor();
        for (int i = 0; i < 3; i++)
        begin
            dem_set(i, 8'h80, 8'h30, 1'b1);
            wr(CTRL, 32'h0);
            repeat (2) @(posedge core_clk);
            check(drv[i], 8'h00);
            wr(CTRL, 32'h1 << (5 + i));
            repeat (2) @(posedge core_clk);
            check(drv[i], 8'h30);
            dem_set(i, 8'h00, 8'h00, 1'b0);
        end
    endtask : t_floor

    // Full sweep 0 to 255: step size, slot spacing, no overshoot
    task automatic ramp(input logic [7:0] c6, input logic [2:0] code, input int slot);
        int inc_tab [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
        int inc;
        int gap;
        int steps;
        logic [7:0] prev;
        inc = inc_tab[code];
        dem_set(0, 8'h00, 8'h00, 1'b0);
        wr(CTRL, 32'h0);
        wr(CFG6, {24'h0, c6});
        check(drv[0], 8'h00);
        wr(CTRL, {28'h0, 1'b1, code});
        dem_set(0, 8'hFF, 8'h00, 1'b0);
        prev = drv[0];
        gap = 0;
        steps = 0;
        while (prev !== 8'hFF && gap <= 2 * slot)
        begin
            @(posedge core_clk);
            gap++;
            if (drv[0] !== prev)
            begin
                check(32'(drv[0] - prev), (255 - prev < inc) ? 32'(255 - prev) : 32'(inc));
                if (steps > 0)
                    check(gap, slot);
                steps++;
                gap = 0;
                prev = drv[0];
            end
        end
        check(steps, (255 + inc - 1) / inc);
    endtask : ramp

    // Grouped fans follow the third drive
    task automatic t_group();
        dem_set(2, 8'h5A, 8'h00, 1'b0);
        wr(CTRL, 32'h10);
        repeat (3) @(posedge core_clk);
        check(fan_three_group, 1'b1);
        for (int i = 0; i < 3; i++)
            check(sense[i], 8'h5A);
        rd_chk(10'h1C4, 32'h005A_00FF);
        wr(CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        check(fan_three_group, 1'b0);
    endtask : t_group

    // Lock freezes the ramp register only; a fresh reset clears the lock and the ramp register
    task automatic t_lock();
        wr(CTRL, 32'h5A);
        wr(LOCK, 32'h1);
        wr(CTRL, 32'hA5);
        rd_chk(CTRL, 32'h5A);
        wr(CFG6, 32'h80);
        rd_chk(CFG6, 32'h80);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(CTRL, 32'h0);
        wr(CTRL, 32'hA5);
        rd_chk(CTRL, 32'hA5);
    endtask : t_lock

    initial
    begin
        for (int i = 0; i < 3; i++)
            dem[i] = '0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_direct();
        t_floor();
        for (int c = 0; c < 8; c++)
            ramp(8'h00, 3'(c), NORM);
        ramp(8'h80, 3'd7, SLOW);
        ramp(8'h01, 3'd6, 4 * NORM);
        ramp(8'h81, 3'd7, 4 * SLOW);
        t_group();
        t_lock();
        finish_test();
    end
endmodule : fan_duty_ramp_smoothing_tb
